// >>> pts_pkg.sv
// Package for the periodic timer with prescale
package pts_pkg;
// Behaviour
// - Timer on: count increments from zero once per prescaled instruction tick
// - Prescale field: 00 divides by 1, 01 by 4, 1x by 16
// - Count compared with period every cycle; equality at a prescaled tick gives match output
// - On a match the count returns to zero at that same tick instead of incrementing
// - Matches clock a postscaler, ratio field code plus one, 1:1 to 1:16
// - Control bit 2 runs the timer; cleared it halts counting
// - Count and period registers readable and writable at any time
// - Reset clears count and sets period to all ones
// - Prescaler and postscaler cleared on count write, control write, reset
// - Control write leaves the count value unchanged
// - Control bit 7 reads zero; other control bits reset to zero
// - Interrupt request comes from match through the postscaler
// - Match output offered as shift clock for the sync serial port
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h1;
    localparam logic [3:0] ADDR_PERIOD = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam int CTRL_ON_BIT = 2;
    localparam int CTRL_PRE_LSB = 0;
    localparam int CTRL_POST_LSB = 3;
    localparam logic [7:0] CTRL_WMASK = 8'h7f;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [3:0] PRE_LAST1 = 4'h0;
    localparam logic [3:0] PRE_LAST4 = 4'h3;
    localparam logic [3:0] PRE_LAST16 = 4'hf;
    typedef struct packed {
        logic [3:0] postscale_select;
        logic timer_on;
        logic [1:0] prescale_select;
    } pts_ctrl_t;
    typedef enum logic [1:0] {
        PTS_IDLE = 2'b00,
        PTS_ANSWER = 2'b01
    } pts_bus_t;
endpackage

// >>> pts_timer.sv
// Periodic timer with prescaler, postscaler and Avalon-MM registers
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pts_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer outputs
    output logic match_out,
    output logic irq
);
    logic [7:0] count_value, next_count;
    logic [7:0] period_value, next_period;
    pts_pkg::pts_ctrl_t timer_control, next_control;
    logic rd_acc;
    logic [1:0] quarter, next_quarter;
    logic [3:0] prescale, next_prescale;
    logic [3:0] postscale, next_postscale;
    logic flag, next_flag;
    logic mask, next_mask;
    logic [31:0] next_rdata;
    logic next_match, next_irq;
    pts_pkg::pts_bus_t bus_state, next_bus;
    logic instr_tick, pre_tick, wr_acc, wr_ctrl, wr_count, hit, post_done;
    logic [3:0] pre_last;

    // Writes land at the edge where waitrequest is seen low
    assign wr_acc = avs_write && bus_state == pts_pkg::PTS_ANSWER;
    assign rd_acc = avs_read && bus_state == pts_pkg::PTS_IDLE;
    assign wr_ctrl = wr_acc && avs_address == pts_pkg::ADDR_CONTROL;
    assign wr_count = wr_acc && avs_address == pts_pkg::ADDR_COUNT;
    assign instr_tick = quarter == 2'(pts_pkg::INSTR_DIV - 1);
    always_comb begin
        case (timer_control.prescale_select)
            pts_pkg::PRE_DIV1: pre_last = pts_pkg::PRE_LAST1;
            pts_pkg::PRE_DIV4: pre_last = pts_pkg::PRE_LAST4;
            default: pre_last = pts_pkg::PRE_LAST16;
        endcase
    end
    assign pre_tick = timer_control.timer_on && instr_tick
        && prescale == pre_last;
    assign hit = count_value == period_value;
    assign post_done = pre_tick && hit
        && postscale == timer_control.postscale_select;

    always_comb begin
        next_quarter = quarter + 2'h1;
        next_prescale = prescale;
        next_postscale = postscale;
        next_count = count_value;
        next_period = period_value;
        next_control = timer_control;
        next_flag = flag;
        next_mask = mask;
        if (timer_control.timer_on && instr_tick) begin
            next_prescale = (prescale == pre_last) ? 4'h0 : prescale + 4'h1;
        end
        if (pre_tick) begin
            if (hit) begin
                next_count = pts_pkg::COUNT_RESET;
                next_postscale = post_done ? 4'h0 : postscale + 4'h1;
            end else begin
                next_count = count_value + 8'h01;
            end
        end
        // sticky flag, set wins over clear
        if (wr_acc && avs_address == pts_pkg::ADDR_STATUS
            && avs_writedata[0]) begin
            next_flag = 1'b0;
        end
        if (post_done) begin
            next_flag = 1'b1;
        end
        if (wr_count) begin
            next_count = avs_writedata[7:0];
        end
        if (wr_acc && avs_address == pts_pkg::ADDR_PERIOD) begin
            next_period = avs_writedata[7:0];
        end
        if (wr_acc && avs_address == pts_pkg::ADDR_MASK) begin
            next_mask = avs_writedata[0];
        end
        if (wr_ctrl) begin
            next_control = pts_pkg::pts_ctrl_t'(avs_writedata[6:0]
                & pts_pkg::CTRL_WMASK[6:0]);
        end
        if (wr_ctrl || wr_count) begin
            next_prescale = 4'h0;
            next_postscale = 4'h0;
        end
    end

    // match for serial port shift clock
    assign next_match = pre_tick && hit;
    assign next_irq = next_flag && next_mask;

    always_comb begin
        next_bus = bus_state;
        next_rdata = avs_readdata;
        case (bus_state)
            pts_pkg::PTS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus = pts_pkg::PTS_ANSWER;
                end
                if (avs_read) begin
                    case (avs_address)
                        pts_pkg::ADDR_CONTROL:
                            next_rdata = {25'h0, timer_control};
                        pts_pkg::ADDR_COUNT: next_rdata = {24'h0, count_value};
                        pts_pkg::ADDR_PERIOD:
                            next_rdata = {24'h0, period_value};
                        pts_pkg::ADDR_STATUS: next_rdata = {31'h0, flag};
                        pts_pkg::ADDR_MASK: next_rdata = {31'h0, mask};
                        default: next_rdata = 32'h0;
                    endcase
                end
            end
            pts_pkg::PTS_ANSWER: next_bus = pts_pkg::PTS_IDLE;
            default: next_bus = pts_pkg::PTS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            quarter <= 2'h0;
            prescale <= 4'h0;
            postscale <= 4'h0;
            count_value <= pts_pkg::COUNT_RESET;
            period_value <= pts_pkg::PERIOD_RESET;
            timer_control <= pts_pkg::pts_ctrl_t'(pts_pkg::CONTROL_RESET[6:0]);
            flag <= 1'b0;
            mask <= 1'b0;
            match_out <= 1'b0;
            irq <= 1'b0;
            bus_state <= pts_pkg::PTS_IDLE;
            avs_readdata <= 32'h0;
            avs_waitrequest <= 1'b1;
        end else begin
            quarter <= next_quarter;
            prescale <= next_prescale;
            postscale <= next_postscale;
            count_value <= next_count;
            period_value <= next_period;
            timer_control <= next_control;
            flag <= next_flag;
            mask <= next_mask;
            match_out <= next_match;
            irq <= next_irq;
            bus_state <= next_bus;
            avs_readdata <= next_rdata;
            avs_waitrequest <= !(next_bus == pts_pkg::PTS_ANSWER);
        end
    end

    AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
        pre_tick && hit && !wr_count |=> count_value == 8'h00)
        else $error("count not cleared after match");
    AST_INC: assert property (@(posedge ref_clk) disable iff (!rstn)
        pre_tick && !hit && !wr_count |=> count_value == $past(count_value)
        + 8'h01)
        else $error("count did not increment");
    AST_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        !timer_control.timer_on && !wr_count |=> $stable(count_value))
        else $error("count moved while off");
    AST_MATCH: assert property (@(posedge ref_clk) disable iff (!rstn)
        match_out |-> $past(hit) && $past(pre_tick))
        else $error("match without compare");
    AST_STICKY: assert property (@(posedge ref_clk) disable iff (!rstn)
        flag && !(wr_acc && avs_address == pts_pkg::ADDR_STATUS) |=> flag)
        else $error("flag dropped");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq == (flag && mask))
        else $error("irq mismatch");
    AST_CTRLW: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_ctrl && !pre_tick |=> $stable(count_value))
        else $error("control write changed count");
    AST_SCLR: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_ctrl || wr_count |=> prescale == 4'h0 && postscale == 4'h0)
        else $error("scalers not cleared");
    AST_BIT7: assert property (@(posedge ref_clk) disable iff (!rstn)
        !avs_waitrequest && $past(avs_address) == pts_pkg::ADDR_CONTROL
        |-> avs_readdata[7] == 1'b0)
        else $error("bit 7 set");
    // postscale ratio 1:1 flags each match
    AST_POST1: assert property (@(posedge ref_clk) disable iff (!rstn)
        timer_control.postscale_select == 4'h0 && pre_tick && hit
        && !wr_ctrl && !wr_count |=> flag)
        else $error("1:1 postscale missed");
    AST_WAIT_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
        bus_state == pts_pkg::PTS_IDLE |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    AST_WAIT_ANSWER: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_acc || (avs_write && bus_state == pts_pkg::PTS_IDLE)
        |=> !avs_waitrequest)
        else $error("request not answered");
    AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (!rstn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_RD_COUNT: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_acc && avs_address == pts_pkg::ADDR_COUNT
        |=> avs_readdata == {24'h0, $past(count_value)})
        else $error("count read wrong");
    AST_RD_PERIOD: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_acc && avs_address == pts_pkg::ADDR_PERIOD
        |=> avs_readdata == {24'h0, $past(period_value)})
        else $error("period read wrong");
    AST_RD_STATUS: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_acc && avs_address == pts_pkg::ADDR_STATUS
        |=> avs_readdata == {31'h0, $past(flag)})
        else $error("status read wrong");
    AST_RD_MASK: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_acc && avs_address == pts_pkg::ADDR_MASK
        |=> avs_readdata == {31'h0, $past(mask)})
        else $error("mask read wrong");
    AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_acc && avs_address > pts_pkg::ADDR_MASK
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_WR_COUNT: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_count |=> count_value == $past(avs_writedata[7:0]))
        else $error("count write lost");
    AST_WR_PERIOD: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && avs_address == pts_pkg::ADDR_PERIOD
        |=> period_value == $past(avs_writedata[7:0]))
        else $error("period write lost");
    AST_PERIOD_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(wr_acc && avs_address == pts_pkg::ADDR_PERIOD)
        |=> $stable(period_value))
        else $error("period changed unasked");
    AST_WR_CTRL: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_ctrl |=> timer_control == $past(avs_writedata[6:0]))
        else $error("control write lost");
    AST_OFF_NO_MATCH: assert property (@(posedge ref_clk) disable iff (!rstn)
        !timer_control.timer_on |=> !match_out)
        else $error("match while off");
    AST_HIT_MATCH: assert property (@(posedge ref_clk) disable iff (!rstn)
        pre_tick && hit |=> match_out)
        else $error("match pulse missed");
    AST_MATCH_PULSE: assert property (@(posedge ref_clk) disable iff (!rstn)
        match_out |=> !match_out)
        else $error("match pulse too long");
    AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
        post_done |=> flag)
        else $error("flag not set");
    AST_FLAG_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
        flag && !post_done && wr_acc && avs_writedata[0]
        && avs_address == pts_pkg::ADDR_STATUS |=> !flag)
        else $error("flag not cleared");
    AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        !mask && !(wr_acc && avs_address == pts_pkg::ADDR_MASK)
        |=> !irq)
        else $error("irq while masked");
    AST_PRE_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
        prescale <= pre_last)
        else $error("prescaler out of range");
    AST_POST_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
        postscale <= timer_control.postscale_select)
        else $error("postscaler out of range");
    AST_DIV1: assert property (@(posedge ref_clk) disable iff (!rstn)
        timer_control.timer_on && instr_tick
        && timer_control.prescale_select == pts_pkg::PRE_DIV1
        |-> pre_tick)
        else $error("divide by one skipped tick");
    AST_INSTR: assert property (@(posedge ref_clk) disable iff (!rstn)
        instr_tick |-> ##4 instr_tick)
        else $error("instruction tick spacing");
    COV_MATCH: cover property (@(posedge ref_clk) match_out);
    COV_IRQ: cover property (@(posedge ref_clk) $rose(irq));
    COV_WRAP: cover property (@(posedge ref_clk) post_done && !wr_ctrl);
    COV_DIV16: cover property (@(posedge ref_clk)
        pre_tick && timer_control.prescale_select[1]);
    COV_FLAG_CLR: cover property (@(posedge ref_clk) $fell(flag));
endmodule
`default_nettype wire

// >>> test_pts_timer.sv
// Self-checking testbench for the periodic timer
`timescale 1ns/1ps
`default_nettype none
module test_pts_timer;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, match_out, irq;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h55;
    int n, m, c, p, k;

    always #20 ref_clk = ~ref_clk;

    pts_timer uut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .match_out(match_out), .irq(irq));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic summarize();
        $display("checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int i;
        logic [31:0] r;
        r = xs();
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= {r[31:8], d};
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 20) begin
            miscompares++;
            summarize();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask

    // Cycles from the previous edge until the next match pulse
    task automatic wait_match(output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (match_out !== 1'b1 && cnt < 5000);
        if (cnt >= 5000) begin
            miscompares++;
            summarize();
        end
    endtask

    // Read answers compared against the oldest expectation
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0)
                chk(avs_readdata, exp_q.pop_front());
            else
                miscompares++;
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(pts_pkg::ADDR_CONTROL, 8'h00);
        rd(pts_pkg::ADDR_COUNT, 8'h00);
        rd(pts_pkg::ADDR_PERIOD, 8'hff);
        rd(4'h5, 8'h00);
        bus(1'b1, pts_pkg::ADDR_CONTROL, 8'hb3);
        rd(pts_pkg::ADDR_CONTROL, 8'h33);
        bus(1'b1, pts_pkg::ADDR_COUNT, 8'h5a);
        bus(1'b1, pts_pkg::ADDR_CONTROL, 8'h01);
        rd(pts_pkg::ADDR_COUNT, 8'h5a);
        p = int'(xs() % 7) + 1;
        bus(1'b1, pts_pkg::ADDR_PERIOD, 8'(p));
        rd(pts_pkg::ADDR_PERIOD, 8'(p));
        repeat (40) @(posedge ref_clk);
        rd(pts_pkg::ADDR_COUNT, 8'h5a);
        // Match spacing for every prescale code
        for (c = 0; c < 4; c++) begin
            bus(1'b1, pts_pkg::ADDR_CONTROL, 8'h00);
            bus(1'b1, pts_pkg::ADDR_COUNT, 8'h00);
            bus(1'b1, pts_pkg::ADDR_CONTROL, 8'h04 | 8'(c));
            wait_match(n);
            wait_match(n);
            m = (c == 0) ? 1 : (c == 1) ? 4 : 16;
            chk(32'(n), 32'((p + 1) * pts_pkg::INSTR_DIV * m));
        end
        // Postscaled interrupt, mask and clear
        k = int'(xs() % 16);
        bus(1'b1, pts_pkg::ADDR_CONTROL, 8'h00);
        bus(1'b1, pts_pkg::ADDR_STATUS, 8'h01);
        bus(1'b1, pts_pkg::ADDR_MASK, 8'h01);
        bus(1'b1, pts_pkg::ADDR_PERIOD, 8'h03);
        bus(1'b1, pts_pkg::ADDR_COUNT, 8'h00);
        bus(1'b1, pts_pkg::ADDR_CONTROL, {1'b0, 4'(k), 3'b100});
        n = 0;
        for (m = 0; m < 3000 && irq !== 1'b1; m++) begin
            @(posedge ref_clk);
            if (match_out === 1'b1)
                n++;
        end
        if (m >= 3000) begin
            miscompares++;
            summarize();
        end
        chk(32'(n), 32'(k + 1));
        bus(1'b1, pts_pkg::ADDR_CONTROL, 8'h00);
        rd(pts_pkg::ADDR_STATUS, 8'h01);
        bus(1'b1, pts_pkg::ADDR_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, pts_pkg::ADDR_MASK, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, pts_pkg::ADDR_STATUS, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        rd(pts_pkg::ADDR_STATUS, 8'h00);
        repeat (2) @(posedge ref_clk);
        summarize();
    end
endmodule
`default_nettype wire
